// File: hdl/pmw_ctrl.sv
// Power-mode, system clock selection and wake controller with APB registers
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Settle field picks 8/16/64/256 slow cycles
// - Source field picks fast, slow/4 or external
// - Wake mask bit per source, resets all ones
// - Stop/sleep wake restarts fast oscillator, then clock resumes
// - Wake detects source edge, not level
// - Stop/sleep wake independent of interrupt enable
// - Only unclocked sources wake from stop/sleep
// - Idle gates core clock, peripherals keep running
// - Enabled interrupt ends idle and vectors
// - Hardware clears idle bit on exit
// - Stop halts clock and kills fast oscillator
// - Stop ends on unmasked wake, enabled or not
// - Sleep disables main regulator, keeps state
// - Sleep wake counts settle delay first
// - Mask writes need open timed window
// - Sleep plus stop is sleep; cleared on exit
// - AA then 55 opens 256-cycle window
module pmw_ctrl #(
   parameter int NWAKE = 8,
   parameter int TAB_WIN_CYC = pmw_pkg::TAB_WINDOW
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Wake sources, asynchronous: pins, LIN wake detector, slow timer
   input wire logic [NWAKE-1:0] wake_src,
   // Interrupt enables per wake source from the interrupt controller
   input wire logic [NWAKE-1:0] irq_en,
   // Clock sources, sampled levels of oscillators
   input wire logic slow_osc,
   input wire logic fast_osc_ready,
   // Clock and power controls
   output logic [1:0] clk_sel_out,
   output logic [3:0] fast_div_out,
   output logic core_clk_gate_n,
   output logic sys_clk_run,
   output logic fast_osc_en,
   output logic main_reg_en,
   // Wake result to the core
   output logic wake_pulse,
   output logic wake_vector_valid,
   output logic [NWAKE-1:0] wake_vector
);
   localparam int CW = $clog2(TAB_WIN_CYC + 1);

   logic [7:0] csel_ff;
   logic [7:0] wmask_ff;
   logic [2:0] pctl_ff;
   logic tab_armed_ff;
   logic [CW-1:0] tab_cnt_ff;
   logic [1:0] clk_act_ff;
   logic [2:0] sw_wait_ff;
   logic [8:0] settle_cnt_ff;
   logic [3:0] osc_cnt_ff;
   logic [NWAKE-1:0] wsrc_ff;
   logic [31:0] prdata_ff;
   logic wake_pulse_ff;
   logic wake_vv_ff;
   logic [NWAKE-1:0] wake_vec_ff;
   pmw_pkg::pmw_state_e state_ff;
   pmw_pkg::pmw_state_e nxt_state;
   logic wr_acc;
   logic rd_acc;
   logic tab_open;
   logic stop_wake;
   logic idle_wake;
   logic [NWAKE-1:0] stop_hits;
   logic [8:0] settle_len;
   logic unmapped;

   pmw_edge_if #(.N(NWAKE)) eif();
   assign eif.raw = wake_src;
   assign eif.slow_raw = slow_osc;

   pmw_edge_sync #(.N(NWAKE)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .e(eif)
   );

   // APB decode; single-cycle slave, answers in the access phase
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign pready = 1'b1;
   assign unmapped = !(paddr == pmw_pkg::CSEL_ADDR || paddr == pmw_pkg::WAKEMASK_ADDR ||
                       paddr == pmw_pkg::PWRCTL_ADDR || paddr == pmw_pkg::TAB_ADDR ||
                       paddr == pmw_pkg::STATUS_ADDR);
   assign pslverr = psel && penable && unmapped;
   assign tab_open = (tab_cnt_ff != '0);

   // Timed window: AA then 55 opens, 00 closes, repeating reopens the full window
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tab_armed_ff <= 1'b0;
         tab_cnt_ff <= '0;
      end else if (wr_acc && paddr == pmw_pkg::TAB_ADDR) begin
         tab_armed_ff <= (pwdata[7:0] == pmw_pkg::TAB_KEY1);
         if (tab_armed_ff && pwdata[7:0] == pmw_pkg::TAB_KEY2) begin
            tab_cnt_ff <= CW'(TAB_WIN_CYC);
         end else if (pwdata[7:0] == pmw_pkg::TAB_CLOSE) begin
            tab_cnt_ff <= '0;
         end else if (tab_open) begin
            tab_cnt_ff <= tab_cnt_ff - 1'b1;
         end
      end else if (tab_open) begin
         tab_cnt_ff <= tab_cnt_ff - 1'b1;
      end
   end

   // Clock select register; protected by the timed window like the mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         csel_ff <= pmw_pkg::CSEL_RST;
      end else if (wr_acc && paddr == pmw_pkg::CSEL_ADDR && tab_open) begin
         csel_ff <= pwdata[7:0];
      end
   end

   // Wake mask register, one enable per source
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wmask_ff <= pmw_pkg::WAKEMASK_RST;
      end else if (wr_acc && paddr == pmw_pkg::WAKEMASK_ADDR && tab_open) begin
         wmask_ff <= pwdata[7:0];
      end
   end

   // Power control bits; hardware clears them on return to run
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pctl_ff <= '0;
      end else if (state_ff != pmw_pkg::PMW_RUN && nxt_state == pmw_pkg::PMW_RUN) begin
         pctl_ff <= '0;
      end else if (wr_acc && paddr == pmw_pkg::PWRCTL_ADDR && state_ff == pmw_pkg::PMW_RUN) begin
         pctl_ff <= pwdata[2:0];
      end
   end

   // Settle length from the field
   always_comb begin
      case (csel_ff[pmw_pkg::SETTLE_LSB +: 2])
         2'h0: settle_len = pmw_pkg::SETTLE_D0;
         2'h1: settle_len = pmw_pkg::SETTLE_D1;
         2'h2: settle_len = pmw_pkg::SETTLE_D2;
         default: settle_len = pmw_pkg::SETTLE_D3;
      endcase
   end

   // Stop/sleep wake: only the edge, gated by mask, blind to interrupt enable
   assign stop_hits = eif.rise & wmask_ff;
   assign stop_wake = (state_ff == pmw_pkg::PMW_STOP || state_ff == pmw_pkg::PMW_SLEEP) &&
                      (stop_hits != '0);
   // Idle ends on any enabled interrupt; its peripherals still run on the clock
   assign idle_wake = (state_ff == pmw_pkg::PMW_IDLE) && ((eif.rise & irq_en) != '0);

   // Mode sequencer
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         pmw_pkg::PMW_RUN: begin
            if (pctl_ff[pmw_pkg::PC_STOP] && pctl_ff[pmw_pkg::PC_SLEEP]) begin
               nxt_state = pmw_pkg::PMW_SLEEP;
            end else if (pctl_ff[pmw_pkg::PC_STOP]) begin
               nxt_state = pmw_pkg::PMW_STOP;
            end else if (pctl_ff[pmw_pkg::PC_IDLE]) begin
               nxt_state = pmw_pkg::PMW_IDLE;
            end
         end
         pmw_pkg::PMW_IDLE: begin
            if (idle_wake) nxt_state = pmw_pkg::PMW_RUN;
         end
         pmw_pkg::PMW_STOP: begin
            if (stop_wake) nxt_state = pmw_pkg::PMW_OSC_ON;
         end
         pmw_pkg::PMW_SLEEP: begin
            if (stop_wake) nxt_state = pmw_pkg::PMW_REG_ON;
         end
         pmw_pkg::PMW_REG_ON: begin
            if (settle_cnt_ff == settle_len) nxt_state = pmw_pkg::PMW_OSC_ON;
         end
         pmw_pkg::PMW_OSC_ON: begin
            if (fast_osc_ready || osc_cnt_ff == pmw_pkg::OSC_START_CYC) nxt_state = pmw_pkg::PMW_RUN;
         end
         default: nxt_state = pmw_pkg::PMW_RUN;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) state_ff <= pmw_pkg::PMW_RUN;
      else state_ff <= nxt_state;
   end

   // Settle delay counted on slow oscillator edges after regulator turn-on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settle_cnt_ff <= '0;
      end else if (state_ff != pmw_pkg::PMW_REG_ON) begin
         settle_cnt_ff <= '0;
      end else if (eif.slow_tick) begin
         settle_cnt_ff <= settle_cnt_ff + 1'b1;
      end
   end

   // Oscillator restart wait, bounded in case ready never comes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) osc_cnt_ff <= '0;
      else if (state_ff != pmw_pkg::PMW_OSC_ON) osc_cnt_ff <= '0;
      else osc_cnt_ff <= osc_cnt_ff + 1'b1;
   end

   // Remember the waking sources for vectoring
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) wsrc_ff <= '0;
      else if (stop_wake) wsrc_ff <= stop_hits;
      else if (idle_wake) wsrc_ff <= eif.rise & irq_en;
   end

   // Wake result; vector only when the waking interrupt is enabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_pulse_ff <= 1'b0;
         wake_vv_ff <= 1'b0;
         wake_vec_ff <= '0;
      end else begin
         wake_pulse_ff <= (state_ff != pmw_pkg::PMW_RUN) && (nxt_state == pmw_pkg::PMW_RUN);
         if (state_ff == pmw_pkg::PMW_IDLE && idle_wake) begin
            wake_vv_ff <= 1'b1;
            wake_vec_ff <= eif.rise & irq_en;
         end else if (state_ff == pmw_pkg::PMW_OSC_ON && nxt_state == pmw_pkg::PMW_RUN) begin
            wake_vv_ff <= ((wsrc_ff & irq_en) != '0);
            wake_vec_ff <= wsrc_ff & irq_en;
         end else begin
            wake_vv_ff <= 1'b0;
            wake_vec_ff <= '0;
         end
      end
   end

   // Source switch only while the clock is held, with a short dead time between sources
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_act_ff <= pmw_pkg::SRC_FAST0;
         sw_wait_ff <= '0;
      end else if (sw_wait_ff != '0) begin
         sw_wait_ff <= sw_wait_ff - 1'b1;
         if (sw_wait_ff == 3'h2) clk_act_ff <= csel_ff[pmw_pkg::CLK_SRC_LSB +: 2];
      end else if (clk_act_ff != csel_ff[pmw_pkg::CLK_SRC_LSB +: 2]) begin
         sw_wait_ff <= 3'h3;
      end
   end

   assign clk_sel_out = clk_act_ff;
   assign fast_div_out = csel_ff[pmw_pkg::DIV_LSB +: 4];
   assign core_clk_gate_n = (state_ff == pmw_pkg::PMW_RUN) && (sw_wait_ff == '0);
   assign sys_clk_run = (state_ff == pmw_pkg::PMW_RUN || state_ff == pmw_pkg::PMW_IDLE) &&
                        (sw_wait_ff == '0);
   assign fast_osc_en = (state_ff != pmw_pkg::PMW_STOP) && (state_ff != pmw_pkg::PMW_SLEEP) &&
                        (state_ff != pmw_pkg::PMW_REG_ON);
   assign main_reg_en = (state_ff != pmw_pkg::PMW_SLEEP);
   assign wake_pulse = wake_pulse_ff;
   assign wake_vector_valid = wake_vv_ff;
   assign wake_vector = wake_vec_ff;

   // Read data registered in the setup cycle so it is ready in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= '0;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            pmw_pkg::CSEL_ADDR: prdata_ff <= {24'h000000, csel_ff[7:4], 2'h0, csel_ff[1:0]};
            pmw_pkg::WAKEMASK_ADDR: prdata_ff <= {24'h000000, wmask_ff};
            pmw_pkg::PWRCTL_ADDR: prdata_ff <= {29'h00000000, pctl_ff};
            pmw_pkg::TAB_ADDR: prdata_ff <= {31'h00000000, tab_open};
            pmw_pkg::STATUS_ADDR: prdata_ff <= {27'h0000000, clk_act_ff, 3'(state_ff)};
            default: prdata_ff <= '0;
         endcase
      end
   end
   assign prdata = rd_acc ? prdata_ff : 32'h00000000;

   // Assertions
   sequence s_key2;
      wr_acc && paddr == pmw_pkg::TAB_ADDR && pwdata[7:0] == pmw_pkg::TAB_KEY2 && tab_armed_ff;
   endsequence
   // Full window loaded on the key pair; a close write may end it early
   property p_tab_open;
      @(posedge pclk) disable iff (!presetn) s_key2 |=> tab_cnt_ff == CW'(TAB_WIN_CYC);
   endproperty
   a_tab_open: assert property (p_tab_open) else $error("window did not open");
   property p_tab_count;
      @(posedge pclk) disable iff (!presetn)
         tab_open && !(wr_acc && paddr == pmw_pkg::TAB_ADDR) |=> tab_cnt_ff == $past(tab_cnt_ff) - 1'b1;
   endproperty
   a_tab_count: assert property (p_tab_count) else $error("window did not count down");
   property p_sw_hold;
      @(posedge pclk) disable iff (!presetn) $changed(clk_sel_out) |-> !sys_clk_run && !$past(sys_clk_run);
   endproperty
   a_sw_hold: assert property (p_sw_hold) else $error("source changed with clock running");
   property p_mask_lock;
      @(posedge pclk) disable iff (!presetn) !tab_open |=> $stable(wmask_ff);
   endproperty
   a_mask_lock: assert property (p_mask_lock) else $error("mask changed while locked");
   property p_sleep_entry;
      @(posedge pclk) disable iff (!presetn)
         state_ff == pmw_pkg::PMW_RUN && pctl_ff[1] && pctl_ff[2] |=> state_ff == pmw_pkg::PMW_SLEEP;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");
   property p_sleep_reg;
      @(posedge pclk) disable iff (!presetn) state_ff == pmw_pkg::PMW_SLEEP |-> !main_reg_en && !fast_osc_en;
   endproperty
   a_sleep_reg: assert property (p_sleep_reg) else $error("regulator on in sleep");
   property p_stop_clk;
      @(posedge pclk) disable iff (!presetn) state_ff == pmw_pkg::PMW_STOP |-> !sys_clk_run && !fast_osc_en;
   endproperty
   a_stop_clk: assert property (p_stop_clk) else $error("clock alive in stop");
   property p_stop_wake;
      @(posedge pclk) disable iff (!presetn) stop_wake && state_ff == pmw_pkg::PMW_STOP |=>
         state_ff == pmw_pkg::PMW_OSC_ON ##[1:5] state_ff == pmw_pkg::PMW_RUN;
   endproperty
   a_stop_wake: assert property (p_stop_wake) else $error("stop wake not finished");
   property p_idle_clear;
      @(posedge pclk) disable iff (!presetn) state_ff == pmw_pkg::PMW_IDLE && idle_wake |=> pctl_ff == 3'h0;
   endproperty
   a_idle_clear: assert property (p_idle_clear) else $error("idle bit not cleared");
   property p_idle_gate;
      @(posedge pclk) disable iff (!presetn) state_ff == pmw_pkg::PMW_IDLE |-> !core_clk_gate_n;
   endproperty
   a_idle_gate: assert property (p_idle_gate) else $error("core clock in idle");
   property p_run_nowake;
      @(posedge pclk) disable iff (!presetn) state_ff == pmw_pkg::PMW_RUN |-> !stop_wake;
   endproperty
   a_run_nowake: assert property (p_run_nowake) else $error("wake seen while running");
endmodule // pmw_ctrl
`default_nettype wire

// File: hdl/pmw_pkg.sv
// Package of offsets, field layouts, reset values and timing for the power-mode and clock controller
package pmw_pkg;
   // Register byte addresses (printed offsets are not word multiples: index times four)
   localparam logic [7:0] CSEL_IDX = 8'h8f;
   localparam logic [7:0] WAKEMASK_IDX = 8'h9f;
   localparam logic [7:0] PWRCTL_IDX = 8'h87;
   localparam logic [7:0] TAB_IDX = 8'hc9;
   localparam logic [7:0] STATUS_IDX = 8'hd0;
   localparam logic [11:0] CSEL_ADDR = {2'h0, CSEL_IDX, 2'h0};
   localparam logic [11:0] WAKEMASK_ADDR = {2'h0, WAKEMASK_IDX, 2'h0};
   localparam logic [11:0] PWRCTL_ADDR = {2'h0, PWRCTL_IDX, 2'h0};
   localparam logic [11:0] TAB_ADDR = {2'h0, TAB_IDX, 2'h0};
   localparam logic [11:0] STATUS_ADDR = {2'h0, STATUS_IDX, 2'h0};
   // Field positions
   localparam int CLK_SRC_LSB = 0;
   localparam int SETTLE_LSB = 2;
   localparam int DIV_LSB = 4;
   localparam int PC_IDLE = 0;
   localparam int PC_STOP = 1;
   localparam int PC_SLEEP = 2;
   // Reset values
   localparam logic [7:0] CSEL_RST = 8'h0c;
   localparam logic [7:0] WAKEMASK_RST = 8'hff;
   // Clock source codes
   localparam logic [1:0] SRC_FAST0 = 2'h0;
   localparam logic [1:0] SRC_SLOW4 = 2'h1;
   localparam logic [1:0] SRC_FAST1 = 2'h2;
   localparam logic [1:0] SRC_EXT = 2'h3;
   // Unlock sequence and window length
   localparam logic [7:0] TAB_KEY1 = 8'haa;
   localparam logic [7:0] TAB_KEY2 = 8'h55;
   localparam logic [7:0] TAB_CLOSE = 8'h00;
   localparam logic [8:0] TAB_WINDOW = 9'h100;
   // Settle delays in slow oscillator cycles
   localparam logic [8:0] SETTLE_D0 = 9'h008;
   localparam logic [8:0] SETTLE_D1 = 9'h010;
   localparam logic [8:0] SETTLE_D2 = 9'h040;
   localparam logic [8:0] SETTLE_D3 = 9'h100;
   // Cycles allowed for the fast oscillator to report ready
   localparam logic [3:0] OSC_START_CYC = 4'h4;
   typedef enum logic [2:0] {PMW_RUN, PMW_IDLE, PMW_STOP, PMW_SLEEP, PMW_REG_ON, PMW_OSC_ON} pmw_state_e;
endpackage

// File: hdl/pmw_edge_if.sv
// Interface carrying wake sources and their synchronised edges
`timescale 1ns/1ps
`default_nettype none
interface pmw_edge_if #(parameter int N = 8);
   logic [N-1:0] raw;
   logic [N-1:0] rise;
   logic slow_raw;
   logic slow_tick;
   modport det (input raw, input slow_raw, output rise, output slow_tick);
   modport ctl (output raw, output slow_raw, input rise, input slow_tick);
endinterface
`default_nettype wire

// File: hdl/pmw_edge_sync.sv
// Three-stage synchroniser with rising-edge detect for wake sources and slow oscillator
`timescale 1ns/1ps
`default_nettype none
module pmw_edge_sync #(parameter int N = 8) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Carrier
   pmw_edge_if.det e
);
   logic [N:0] s1_ff;
   logic [N:0] s2_ff;
   logic [N:0] s3_ff;
   logic [N:0] lvl_ff;
   // Only stage two reads stage one; edges are taken from stages two and three
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else begin
         s1_ff <= {e.slow_raw, e.raw};
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end
   // Agreed level: a change counts only once stages two and three match, so a runt is ignored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvl_ff <= '0;
      end else begin
         lvl_ff <= (s2_ff & s3_ff) | (lvl_ff & (s2_ff | s3_ff));
      end
   end
   // Edge only, whatever the interrupt trigger type
   assign e.rise = s2_ff[N-1:0] & s3_ff[N-1:0] & ~lvl_ff[N-1:0];
   assign e.slow_tick = s2_ff[N] & s3_ff[N] & ~lvl_ff[N];
endmodule // pmw_edge_sync
`default_nettype wire

// File: verification/pmw_core_model.sv
// Partner model of the core side: wake pins, slow oscillator and fast oscillator start-up
`timescale 1ns/1ps
`default_nettype none
module pmw_core_model #(parameter int OSC_LAG = 2) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Wake levels asked for by the bench
   input wire logic [7:0] src_lvl,
   // Design side
   input wire logic fast_osc_en,
   output logic [7:0] wake_src,
   output logic slow_osc,
   output logic fast_osc_ready
);
   int lag;
   // Slow oscillator never stops and is unrelated in phase to pclk
   initial begin
      slow_osc = 1'b0;
      forever #190 slow_osc = ~slow_osc;
   end
   // Wake pins follow the bench just after an edge, like external logic
   always @(posedge pclk) wake_src <= src_lvl;
   // Ready only some cycles after enable, so a design that skips the wait is seen
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lag <= 0;
         fast_osc_ready <= 1'b1;
      end else if (!fast_osc_en) begin
         lag <= 0;
         fast_osc_ready <= 1'b0;
      end else if (lag < OSC_LAG) begin
         lag <= lag + 1;
      end else begin
         fast_osc_ready <= 1'b1;
      end
   end
endmodule // pmw_core_model
`default_nettype wire

// File: verification/tb.sv
// Self-checking bench for the power-mode and clock controller
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int WIN = 16;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [7:0] irq_en = 8'h00;
   logic [7:0] src_lvl = 8'h00;
   logic [31:0] prdata;
   logic pready, pslverr, slow_osc, fast_osc_ready, core_clk_gate_n, sys_clk_run;
   logic fast_osc_en, main_reg_en, wake_pulse, wake_vector_valid;
   logic [7:0] wake_src, wake_vector;
   logic [1:0] clk_sel_out;
   logic [3:0] fast_div_out;
   logic [31:0] rd;
   logic er;
   int error_cnt = 0;
   int n_checks = 0;
   int pulses = 0;
   int vcnt = 0;
   logic [7:0] last_vec = 8'h00;
   always #25 pclk = ~pclk;
   pmw_ctrl #(.NWAKE(8), .TAB_WIN_CYC(WIN)) i_pmw_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .wake_src(wake_src), .irq_en(irq_en), .slow_osc(slow_osc),
      .fast_osc_ready(fast_osc_ready), .clk_sel_out(clk_sel_out), .fast_div_out(fast_div_out),
      .core_clk_gate_n(core_clk_gate_n), .sys_clk_run(sys_clk_run), .fast_osc_en(fast_osc_en),
      .main_reg_en(main_reg_en), .wake_pulse(wake_pulse), .wake_vector_valid(wake_vector_valid),
      .wake_vector(wake_vector));
   pmw_core_model i_pmw_core_model (.pclk(pclk), .presetn(presetn), .src_lvl(src_lvl),
      .fast_osc_en(fast_osc_en), .wake_src(wake_src), .slow_osc(slow_osc), .fast_osc_ready(fast_osc_ready));
   // One-cycle pulses are caught in the cycle they stand
   always @(posedge pclk) begin
      if (wake_pulse === 1'b1) pulses <= pulses + 1;
      if (wake_vector_valid === 1'b1) vcnt <= vcnt + 1;
      if (wake_vector_valid === 1'b1) last_vec <= wake_vector;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // Two-phase bus cycle; read data taken at the edge where pready is sampled
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge pclk);
      end
      if (n >= 50) chk(1'b0, 1'b1, "pready");
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic unlock;
      apb(1, pmw_pkg::TAB_ADDR, {24'h0, pmw_pkg::TAB_KEY1});
      apb(1, pmw_pkg::TAB_ADDR, {24'h0, pmw_pkg::TAB_KEY2});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // Bounded wait for the full clock to come back
   task automatic wait_run;
      int c;
      c = 0;
      while (!(sys_clk_run === 1'b1 && core_clk_gate_n === 1'b1) && c < 4000) begin
         c++;
         @(posedge pclk);
      end
      if (c >= 4000) chk(32'h0, 32'h1, "run timeout");
      cyc(3);
   endtask
   task automatic t_reset;
      apb(0, pmw_pkg::CSEL_ADDR, 0);
      chk(rd, {24'h0, pmw_pkg::CSEL_RST & 8'hf3}, "source select reset"); // Fast source
      apb(0, pmw_pkg::WAKEMASK_ADDR, 0);
      chk(rd, 32'hff, "mask reset"); // All wake bits set
      chk({30'h0, clk_sel_out}, 32'h0, "source reset"); // Fast source
      apb(0, 12'h004, 0);
      chk(rd, 32'h0, "unmapped data");
      chk({31'h0, er}, 32'h1, "unmapped error");
   endtask
   task automatic t_window;
      apb(1, pmw_pkg::WAKEMASK_ADDR, 32'h00);
      apb(0, pmw_pkg::WAKEMASK_ADDR, 0);
      chk(rd, 32'hff, "locked write"); // Closed window refuses
      unlock();
      apb(0, pmw_pkg::TAB_ADDR, 0);
      chk(rd & 32'h1, 32'h1, "window open"); // Key pair opens
      apb(1, pmw_pkg::WAKEMASK_ADDR, 32'h5a);
      apb(0, pmw_pkg::WAKEMASK_ADDR, 0);
      chk(rd, 32'h5a, "open write"); // Open window accepts
      cyc(WIN + 4);
      apb(1, pmw_pkg::WAKEMASK_ADDR, 32'hff);
      apb(0, pmw_pkg::WAKEMASK_ADDR, 0);
      chk(rd, 32'h5a, "expired write"); // Window expires
      unlock();
      apb(1, pmw_pkg::TAB_ADDR, 32'h00);
      apb(1, pmw_pkg::WAKEMASK_ADDR, 32'hff);
      apb(0, pmw_pkg::WAKEMASK_ADDR, 0);
      chk(rd, 32'h5a, "closed write"); // Zero closes window
   endtask
   task automatic t_stop;
      int p0;
      int v0;
      int c;
      unlock();
      apb(1, pmw_pkg::WAKEMASK_ADDR, 32'h01);
      irq_en <= 8'h00;
      p0 = pulses;
      v0 = vcnt;
      src_lvl <= 8'h01;
      cyc(8);
      chk(pulses, p0, "run edge"); // Edge while running ignored
      // Clock source left on the fast oscillator before stop
      apb(1, pmw_pkg::PWRCTL_ADDR, 32'h2);
      cyc(4);
      chk({fast_osc_en, sys_clk_run, main_reg_en}, 3'b001, "stopped"); // Stop kills clock
      src_lvl <= 8'h03;
      cyc(12);
      chk(sys_clk_run, 1'b0, "level or masked"); // Held level, masked edge
      src_lvl <= 8'h00;
      cyc(4);
      src_lvl <= 8'h01;
      c = 0;
      while (fast_osc_en !== 1'b1 && c < 100) begin
         c++;
         @(posedge pclk);
      end
      chk({fast_osc_en, sys_clk_run}, 2'b10, "osc first"); // Oscillator before clock
      wait_run();
      chk(pulses, p0 + 1, "stop wake"); // Unmasked edge wakes
      chk(vcnt, v0, "no vector"); // Disabled irq wakes without a vector
      cyc(10);
      chk({sys_clk_run, clk_sel_out}, 3'b100, "stays run"); // Stop bit cleared, source kept
      src_lvl <= 8'h00;
   endtask
   task automatic t_sleep(input int code, input bit wr_code);
      int n;
      int c;
      int exp;
      logic prev;
      int dly [4] = '{8, 16, 64, 256};
      exp = dly[code];
      if (wr_code) unlock();
      if (wr_code) apb(1, pmw_pkg::CSEL_ADDR, 32'(code << 2));
      apb(1, pmw_pkg::PWRCTL_ADDR, 32'h6);
      cyc(4);
      chk({main_reg_en, fast_osc_en}, 2'b00, "sleeping"); // Regulator off in sleep
      src_lvl <= 8'h01;
      c = 0;
      while (main_reg_en !== 1'b1 && c < 100) begin
         c++;
         @(posedge pclk);
      end
      chk({main_reg_en, fast_osc_en}, 2'b10, "regulator first"); // Regulator before oscillator
      n = 0;
      prev = slow_osc;
      while (fast_osc_en !== 1'b1 && c < 5000) begin
         c++;
         if (slow_osc === 1'b1 && prev === 1'b0) n++;
         prev = slow_osc;
         @(posedge pclk);
      end
      n_checks++;
      if (n < exp - 1 || n > exp + 1) begin // Settle count per field
         error_cnt++;
         $display("Error at %0t: settle code %0d took %0d slow edges", $time, code, n);
      end
      wait_run();
      src_lvl <= 8'h00;
      cyc(4);
   endtask
   task automatic t_idle;
      int p0;
      int v0;
      p0 = pulses;
      v0 = vcnt;
      irq_en <= 8'h04;
      apb(1, pmw_pkg::PWRCTL_ADDR, 32'h1);
      cyc(2);
      chk({core_clk_gate_n, sys_clk_run}, 2'b01, "idle gates"); // Core gated, system runs
      src_lvl <= 8'h02;
      cyc(10);
      chk(core_clk_gate_n, 1'b0, "disabled irq"); // Only enabled irq ends idle
      src_lvl <= 8'h06;
      wait_run();
      chk(pulses, p0 + 1, "idle pulse"); // Clock restored once
      chk(vcnt, v0 + 1, "idle vector valid"); // Vectors to source
      chk({24'h0, last_vec}, 32'h04, "idle vector"); // Enabled waking source only
      cyc(10);
      chk(core_clk_gate_n, 1'b1, "idle cleared"); // Idle bit cleared on exit
      src_lvl <= 8'h00;
   endtask
   task automatic t_source;
      for (int i = 3; i >= 0; i--) begin
         unlock();
         apb(1, pmw_pkg::CSEL_ADDR, 32'h0c | 32'(i) | 32'(i << 4));
         cyc(8);
         chk({30'h0, clk_sel_out}, 32'(i), "source"); // Each source code
         chk({28'h0, fast_div_out}, 32'(i), "divider"); // Divider field follows write
      end
   endtask
   task automatic results;
      $display("Comparisons %0d, mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Main sequence; default settle code is used before any clock-select write
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_window();
      t_stop();
      t_sleep(3, 1'b0);
      t_sleep(0, 1'b1);
      t_sleep(1, 1'b1);
      t_sleep(2, 1'b1);
      t_idle();
      t_source();
      results();
   end
   // Watchdog well beyond the few thousand cycles the run needs
   initial begin
      #1000000;
      error_cnt++;
      results();
   end
endmodule // tb
`default_nettype wire
